// ### src/cwg_defs.svh
// Timing and field constants of the complementary wave generator
`ifndef CWG_DEFS_SVH
`define CWG_DEFS_SVH
`define CWG_DB_W 6
`define CWG_DB_ZERO 6'h00
`define CWG_SRC_N 2
`define CWG_SRC_NONE 2'h0
`endif

// ### src/cwg_pkg.sv
// Types shared by the complementary wave generator
package cwg_pkg;
    typedef enum logic [3:0] {
        CWG_OFF = 4'h1,
        CWG_SHUT = 4'h2,
        CWG_ARM = 4'h4,
        CWG_RUN = 4'h8
    } cwg_state_e;
endpackage : cwg_pkg

// ### src/cwg_core.sv
// Complementary wave generator with auto-shutdown and restart control
`include "cwg_defs.svh"
module cwg_core #(
    parameter int DB_W = `CWG_DB_W,
    parameter int SRC_N = `CWG_SRC_N
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic waveform_gen_enable,
    input wire logic auto_restart_enable,
    input wire logic shutdown_flag_set,
    input wire logic shutdown_flag_clear,
    input wire logic override_level_a,
    input wire logic override_level_b,
    input wire logic polarity_a,
    input wire logic polarity_b,
    input wire logic osc_select,
    input wire logic [SRC_N-1:0] shutdown_select,
    input wire logic [DB_W-1:0] rising_deadband_reg,
    input wire logic [DB_W-1:0] falling_deadband_reg,
    input wire logic wave_in,
    input wire logic [SRC_N-1:0] shutdown_in,
    output logic shutdown_state_flag,
    output logic osc_keep_on,
    output logic output_a,
    output logic output_b
);
    default clocking dflt_cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [SRC_N:0] sync1;
    logic [SRC_N:0] sync2;
    logic in_prev;
    logic in_s;
    logic [SRC_N-1:0] sd_s;
    logic sd_any;
    logic rise;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1 <= '0;
            sync2 <= '0;
            in_prev <= 1'b0;
        end
        else
        begin
            sync1 <= {shutdown_in, wave_in};
            sync2 <= sync1;
            in_prev <= sync2[0];
        end
    end

    assign in_s = sync2[0];
    assign sd_s = sync2[SRC_N:1];
    assign sd_any = |(sd_s & shutdown_select);
    assign rise = in_s & ~in_prev;

    // ****************************************
    // Shutdown flag and restart sequencing
    // ****************************************
    cwg_pkg::cwg_state_e state;
    cwg_pkg::cwg_state_e next_state;
    logic next_flag;

    always_comb
    begin
        next_flag = shutdown_state_flag;
        next_state = state;
        // Set wins over any clear while waveform_gen_enable is high
        if (waveform_gen_enable && (sd_any || shutdown_flag_set))
            next_flag = 1'b1;
        else if (shutdown_state_flag && !sd_any &&
                 (shutdown_flag_clear || auto_restart_enable))
            next_flag = 1'b0;
        case (state)
            cwg_pkg::CWG_OFF:
                if (waveform_gen_enable)
                    next_state = cwg_pkg::CWG_SHUT;
            cwg_pkg::CWG_SHUT:
                if (!next_flag)
                    next_state = cwg_pkg::CWG_ARM;
            cwg_pkg::CWG_ARM:
                if (next_flag)
                    next_state = cwg_pkg::CWG_SHUT;
                else if (rise)
                    next_state = cwg_pkg::CWG_RUN;
            cwg_pkg::CWG_RUN:
                if (next_flag)
                    next_state = cwg_pkg::CWG_SHUT;
            default:
                next_state = cwg_pkg::CWG_OFF;
        endcase
        if (!waveform_gen_enable)
            next_state = cwg_pkg::CWG_OFF;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= cwg_pkg::CWG_OFF;
            shutdown_state_flag <= 1'b1;
        end
        else
        begin
            state <= next_state;
            shutdown_state_flag <= next_flag;
        end
    end

    sequence s_armed_quiet;
        state == cwg_pkg::CWG_ARM && !rise;
    endsequence

    chk_clear_blocked: assert property (
        (shutdown_state_flag && sd_any) |=> shutdown_state_flag)
        else $error("flag cleared while shutdown input high");

    chk_auto_clear: assert property (
        (shutdown_state_flag && auto_restart_enable && !sd_any &&
         !shutdown_flag_set) |=> !shutdown_state_flag)
        else $error("auto restart did not clear flag");

    chk_sd_sets: assert property (
        (waveform_gen_enable && sd_any) |=> shutdown_state_flag)
        else $error("shutdown input did not set flag");

    chk_hold_edge: assert property (
        s_armed_quiet |=> state != cwg_pkg::CWG_RUN)
        else $error("resumed before rising edge");

    // ****************************************
    // Dead-band generation
    // ****************************************
    logic raw_a;
    logic raw_b;
    logic [DB_W-1:0] db_cnt;
    logic [DB_W-1:0] next_db_cnt;
    logic next_raw_a;
    logic next_raw_b;
    logic run;

    assign run = (state == cwg_pkg::CWG_RUN) && !next_flag;

    always_comb
    begin
        next_db_cnt = db_cnt;
        next_raw_a = raw_a;
        next_raw_b = raw_b;
        if (!run)
        begin
            next_raw_a = 1'b0;
            next_raw_b = 1'b0;
            // Preload: first rise after a restart needs its dead band too
            next_db_cnt = rising_deadband_reg;
        end
        else if (in_s != in_prev)
        begin
            // Both off, then count the dead band for the new edge
            next_raw_a = 1'b0;
            next_raw_b = 1'b0;
            next_db_cnt = in_s ? rising_deadband_reg
                               : falling_deadband_reg;
        end
        else if (db_cnt != `CWG_DB_ZERO)
            next_db_cnt = db_cnt - 1'b1;
        else
        begin
            next_raw_a = in_s;
            next_raw_b = ~in_s;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            db_cnt <= `CWG_DB_ZERO;
            raw_a <= 1'b0;
            raw_b <= 1'b0;
        end
        else
        begin
            db_cnt <= next_db_cnt;
            raw_a <= next_raw_a;
            raw_b <= next_raw_b;
        end
    end

    chk_deadband: assert property (
        !(raw_a && raw_b))
        else $error("both outputs active together");

    // ****************************************
    // Output selection
    // ****************************************
    // Override path bypasses polarity on purpose; combinational so a
    // shutdown takes the pins with no extra cycle after the flag
    always_comb
    begin
        if (state != cwg_pkg::CWG_RUN || shutdown_state_flag)
        begin
            output_a = override_level_a;
            output_b = override_level_b;
        end
        else
        begin
            output_a = raw_a ^ polarity_a;
            output_b = raw_b ^ polarity_b;
        end
    end

    chk_shut_override: assert property (
        shutdown_state_flag |-> (output_a == override_level_a &&
                                 output_b == override_level_b))
        else $error("override levels not driven in shutdown");

    chk_no_polarity: assert property (
        (state != cwg_pkg::CWG_RUN && polarity_a) |->
            output_a == override_level_a)
        else $error("polarity applied to override");

    // Oscillator request for Sleep
    assign osc_keep_on = waveform_gen_enable & osc_select & in_s;
    // No gating on a system clock here, so Sleep does not stop it

    chk_osc_req: assert property (
        (waveform_gen_enable && osc_select && in_s) |-> osc_keep_on)
        else $error("oscillator request missing");
endmodule : cwg_core

// ### sim/cwg_pwr_model.sv
// Behavioural model of the external power stage behind the generator
module cwg_pwr_model (
    input wire logic mclk,
    input wire logic output_a,
    input wire logic output_b,
    input wire logic fault_cmd,
    output logic [1:0] fault_out,
    output int shoot_count
);
    timeunit 1ns;
    timeprecision 1ns;
    // Desaturation fault on source 0 only; source 1 stays quiet
    assign fault_out = {1'b0, fault_cmd};
    int shoots = 0;
    assign shoot_count = shoots;
    // Both switches on together shorts the rail
    always @(posedge mclk)
        if (output_a && output_b) shoots <= shoots + 1;
endmodule : cwg_pwr_model

// ### sim/tb_cwg_core.sv
// Self-checking testbench of the complementary wave generator
module tb_cwg_core;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, arst_n = 0, en = 0, ar = 0, fset = 0, fclr = 0;
    logic ola = 1, olb = 0, pola = 1, polb = 0, osc = 1, wave = 0;
    logic fcmd = 0, flag, keep, oa, ob;
    logic [1:0] ssel = 2'h1;
    logic [1:0] sd_in;
    logic [5:0] dbr = 6'h03;
    logic [5:0] dbf = 6'h02;
    int shoot, bad_count = 0, num_checks = 0;
    always #25 mclk = ~mclk;
    cwg_core cwg_core_inst (.mclk(mclk), .arst_n(arst_n),
        .waveform_gen_enable(en), .auto_restart_enable(ar),
        .shutdown_flag_set(fset), .shutdown_flag_clear(fclr),
        .override_level_a(ola), .override_level_b(olb),
        .polarity_a(pola), .polarity_b(polb), .osc_select(osc),
        .shutdown_select(ssel), .rising_deadband_reg(dbr),
        .falling_deadband_reg(dbf), .wave_in(wave), .shutdown_in(sd_in),
        .shutdown_state_flag(flag), .osc_keep_on(keep),
        .output_a(oa), .output_b(ob));
    cwg_pwr_model cwg_pwr_model_inst (.mclk(mclk), .output_a(oa),
        .output_b(ob), .fault_cmd(fcmd), .fault_out(sd_in),
        .shoot_count(shoot));
    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic chk(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask : chk
    // Selector: 0 flag, 1 output_a, 2 output_b
    function automatic logic pick(input int k);
        return k == 0 ? flag : (k == 1 ? oa : ob);
    endfunction : pick
    task automatic wait_for(input int k, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && pick(k) !== v; i++) @(negedge mclk);
        num_checks++;
        if (pick(k) !== v)
        begin
            bad_count++;
            $display("[ERR] wait %0d expected %b seen %b", k, v, pick(k));
            conclude();
        end
    endtask : wait_for
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_override();
        chk("flag", 1'b1, flag);
        chk("out_a", ola, oa);
        chk("out_b", olb, ob);
        en = 1;
        repeat (2) @(negedge mclk);
        ola = 0;
        olb = 1;
        @(negedge mclk);
        chk("out_a", 1'b0, oa);
        chk("out_b", 1'b1, ob);
        pola = 0;
        $display("t_override done");
    endtask : t_override
    task automatic t_refuse();
        fcmd = 1;
        repeat (4) @(negedge mclk);
        fclr = 1;
        repeat (3) @(negedge mclk);
        chk("flag", 1'b1, flag);
        fclr = 0;
        fcmd = 0;
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_restart();
        repeat (4) @(negedge mclk);
        fclr = 1;
        @(negedge mclk);
        fclr = 0;
        wait_for(0, 1'b0, 5);
        repeat (10) @(negedge mclk);
        chk("out_a", ola, oa);
        chk("out_b", olb, ob);
        wave = 1;
        wait_for(1, 1'b1, 20);
        chk("out_b", 1'b0, ob);
        chk("keep", 1'b1, keep);
        wave = 0;
        wait_for(2, 1'b1, 20);
        chk("out_a", 1'b0, oa);
        chk("keep", 1'b0, keep);
        $display("t_restart done");
    endtask : t_restart
    task automatic t_fault();
        wave = 1;
        wait_for(1, 1'b1, 20);
        fcmd = 1;
        wait_for(0, 1'b1, 5);
        chk("out_a", ola, oa);
        chk("out_b", olb, ob);
        $display("t_fault done");
    endtask : t_fault
    task automatic t_auto();
        ar = 1;
        wave = 0;
        repeat (4) @(negedge mclk);
        chk("flag", 1'b1, flag);
        fcmd = 0;
        wait_for(0, 1'b0, 6);
        wave = 1;
        wait_for(1, 1'b1, 20);
        chk("shoot", 1'b1, shoot == 0);
        pola = 1;
        osc = 0;
        @(negedge mclk);
        chk("out_a", 1'b0, oa);
        chk("keep", 1'b0, keep);
        fset = 1;
        @(negedge mclk);
        chk("flag", 1'b1, flag);
        fset = 0;
        wait_for(0, 1'b0, 3);
        $display("t_auto done");
    endtask : t_auto
    initial
    begin
        repeat (20) @(negedge mclk);
        arst_n = 1;
        @(negedge mclk);
        t_override();
        t_refuse();
        t_restart();
        t_fault();
        t_auto();
        conclude();
    end
endmodule : tb_cwg_core
